// [pkg/cbte_pkg.sv]
// Purpose: shared constants and types of the can bit timing engine
// Assumes: 8-bit register port, three timing registers
// Notes: field positions follow the three control registers
package cbte_pkg;
   localparam int unsigned CBTE_ADDR_W = 2;
   localparam int unsigned CBTE_DATA_W = 8;
   // register addresses
   localparam logic [1:0] CBTE_ADDR_ONE = 2'h0;
   localparam logic [1:0] CBTE_ADDR_TWO = 2'h1;
   localparam logic [1:0] CBTE_ADDR_THREE = 2'h2;
   localparam logic [1:0] CBTE_ADDR_STATUS = 2'h3;
   // reset values
   localparam logic [7:0] CBTE_ONE_RST = 8'h00;
   localparam logic [7:0] CBTE_TWO_RST = 8'h00;
   localparam logic [7:0] CBTE_THREE_RST = 8'h00;
   // field positions: one = {jump[7:6], prescaler[5:0]}
   localparam int unsigned CBTE_PRESC_LSB = 0;
   localparam int unsigned CBTE_PRESC_W = 6;
   localparam int unsigned CBTE_JUMP_LSB = 6;
   localparam int unsigned CBTE_JUMP_W = 2;
   // two = {src[7], triple[6], phase1[5:3], prop[2:0]}
   localparam int unsigned CBTE_PROP_LSB = 0;
   localparam int unsigned CBTE_PH1_LSB = 3;
   localparam int unsigned CBTE_TRIPLE_BIT = 6;
   localparam int unsigned CBTE_SRC_BIT = 7;
   // three = {phase2_len_field[2:0]}
   localparam int unsigned CBTE_PH2_LSB = 0;
   localparam int unsigned CBTE_SEG_W = 3;
   localparam int unsigned CBTE_CNT_W = 5;
   localparam logic [4:0] CBTE_SYNC_TQ = 5'h01;
   localparam logic [4:0] CBTE_IPT_TQ = 5'h02;

   typedef struct packed {
      logic [CBTE_PRESC_W-1:0] quantum_prescaler;
      logic [CBTE_JUMP_W-1:0] resync_jump_sel;
      logic [CBTE_SEG_W-1:0] propagation_len;
      logic [CBTE_SEG_W-1:0] phase1_len;
      logic [CBTE_SEG_W-1:0] phase2_len_field;
      logic triple_sample_en;
      logic phase2_source_sel;
   } cbte_timing_type;

   typedef struct packed {
      logic bit_start;
      logic sample_point;
      logic rx_bit;
   } cbte_bit_type;

   typedef enum logic [1:0] {
      CBTE_SEG_SYNC,
      CBTE_SEG_PROP,
      CBTE_SEG_PH1,
      CBTE_SEG_PH2
   } cbte_seg_type;
endpackage

// [rtl/cbte_bit_timing.sv]
// Purpose: time quantum divider, nominal bit segmenting and bus sampling
// Assumes: config_mode comes from the controller mode logic on clk
// Notes: registers reached over a plain address/strobe port
//
// Notes on behaviour
// RQ1 - software keeps propagation plus phase 1 at least phase 2
// RQ2 - software keeps phase 2 at least the resync jump width
// RQ3 - timing registers take writes only in configuration mode
// RQ4 - prescaler field sets the divider giving one time quantum
// RQ5 - two-bit field selects resync jump width in whole quanta
// RQ6 - propagation and phase 1 lengths come from their own fields
// RQ7 - the sample point sits at the end of phase 1
// RQ8 - triple mode samples twice at half-quantum steps, then at sample point
// RQ9 - triple mode result is the majority of three samples
// RQ10 - single mode samples the pin once at the sample point
// RQ11 - source bit 1 takes phase 2 length from its three-bit field
// RQ12 - source bit 0 takes max of phase 1 and two quanta
// RQ13 - source bit 0 ignores the phase 2 field completely
// RQ14 - software should use a jump width of one, larger only for bad clocks
// RQ15 - quantum is two times prescaler plus one oscillator periods
// RQ16 - bit is sync, propagation, phase 1, phase 2; length is their sum
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module cbte_bit_timing
   import cbte_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // mode
   input wire logic config_mode,
   // register port
   input wire logic [CBTE_ADDR_W-1:0] reg_addr,
   input wire logic [CBTE_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [CBTE_DATA_W-1:0] reg_rdata,
   // bus pin
   input wire logic bus_receive_pin,
   // bit stream
   output cbte_bit_type bit_out,
   output logic [CBTE_JUMP_W:0] resync_jump_tq,
   output logic [CBTE_CNT_W-1:0] bit_len_tq
);
   logic [CBTE_DATA_W-1:0] bit_timing_ctrl_one_reg;
   logic [CBTE_DATA_W-1:0] bit_timing_ctrl_two_reg;
   logic [CBTE_DATA_W-1:0] bit_timing_ctrl_three_reg;
   cbte_timing_type cfg;
   logic rx_meta_reg;
   logic rx_sync_reg;
   logic [CBTE_PRESC_W:0] half_cnt_reg;
   logic half_tick;
   logic half_phase_reg;
   logic tq_tick;
   cbte_seg_type seg_reg;
   logic [CBTE_CNT_W-1:0] seg_cnt_reg;
   logic [CBTE_CNT_W-1:0] seg_len;
   logic [CBTE_CNT_W-1:0] phase1_tq;
   logic [CBTE_CNT_W-1:0] phase2_len;
   logic [2:0] samples_reg;
   logic last_ph1_tq;

   // field decode
   always_comb begin
      cfg.quantum_prescaler = bit_timing_ctrl_one_reg[CBTE_PRESC_LSB +: CBTE_PRESC_W]; // [RQ4]
      cfg.resync_jump_sel = bit_timing_ctrl_one_reg[CBTE_JUMP_LSB +: CBTE_JUMP_W]; // [RQ5]
      cfg.propagation_len = bit_timing_ctrl_two_reg[CBTE_PROP_LSB +: CBTE_SEG_W]; // [RQ6]
      cfg.phase1_len = bit_timing_ctrl_two_reg[CBTE_PH1_LSB +: CBTE_SEG_W]; // [RQ6]
      cfg.triple_sample_en = bit_timing_ctrl_two_reg[CBTE_TRIPLE_BIT];
      cfg.phase2_source_sel = bit_timing_ctrl_two_reg[CBTE_SRC_BIT];
      cfg.phase2_len_field = bit_timing_ctrl_three_reg[CBTE_PH2_LSB +: CBTE_SEG_W];
   end

   // register writes, only while in configuration mode
   always_ff @(posedge clk) begin
      if (srst) begin
         bit_timing_ctrl_one_reg <= CBTE_ONE_RST;
         bit_timing_ctrl_two_reg <= CBTE_TWO_RST;
         bit_timing_ctrl_three_reg <= CBTE_THREE_RST;
      end else if (reg_wr && config_mode) begin // [RQ3]
         unique case (reg_addr)
            CBTE_ADDR_ONE: bit_timing_ctrl_one_reg <= reg_wdata;
            CBTE_ADDR_TWO: bit_timing_ctrl_two_reg <= reg_wdata;
            CBTE_ADDR_THREE: bit_timing_ctrl_three_reg <= {5'h00, reg_wdata[CBTE_SEG_W-1:0]};
            default: begin
            end
         endcase
      end
   end

   // read data one cycle after the strobe; status shows the running segment
   always_ff @(posedge clk) begin
      if (srst) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         unique case (reg_addr)
            CBTE_ADDR_ONE: reg_rdata <= bit_timing_ctrl_one_reg;
            CBTE_ADDR_TWO: reg_rdata <= bit_timing_ctrl_two_reg;
            CBTE_ADDR_THREE: reg_rdata <= bit_timing_ctrl_three_reg;
            default: reg_rdata <= {3'h0, seg_reg, samples_reg};
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

   // two-flop synchroniser on the bus pin
   always_ff @(posedge clk) begin
      if (srst) begin
         rx_meta_reg <= 1'b1;
         rx_sync_reg <= 1'b1;
      end else begin
         rx_meta_reg <= bus_receive_pin;
         rx_sync_reg <= rx_meta_reg;
      end
   end

   // half-quantum divider: prescaler+1 clocks per half, so a quantum is 2*(p+1)
   assign half_tick = (half_cnt_reg == {1'b0, cfg.quantum_prescaler}); // [RQ15]
   assign tq_tick = half_tick && half_phase_reg;

   always_ff @(posedge clk) begin
      if (srst || config_mode) begin
         half_cnt_reg <= '0;
         half_phase_reg <= 1'b0;
      end else if (half_tick) begin
         half_cnt_reg <= '0;
         half_phase_reg <= ~half_phase_reg;
      end else begin
         half_cnt_reg <= half_cnt_reg + 1'b1;
      end
   end

   // segment lengths in quanta; fields hold length minus one
   assign phase1_tq = CBTE_CNT_W'(cfg.phase1_len) + 1'b1;
   always_comb begin
      if (cfg.phase2_source_sel) begin
         phase2_len = CBTE_CNT_W'(cfg.phase2_len_field) + 1'b1; // [RQ11]
      end else begin
         // field not consulted at all on this path
         phase2_len = (phase1_tq > CBTE_IPT_TQ) ? phase1_tq : CBTE_IPT_TQ; // [RQ12] [RQ13]
      end
   end

   always_comb begin
      unique case (seg_reg)
         CBTE_SEG_SYNC: seg_len = CBTE_SYNC_TQ;
         CBTE_SEG_PROP: seg_len = CBTE_CNT_W'(cfg.propagation_len) + 1'b1;
         CBTE_SEG_PH1: seg_len = phase1_tq;
         CBTE_SEG_PH2: seg_len = phase2_len;
      endcase
   end

   // segment sequencer
   always_ff @(posedge clk) begin
      if (srst || config_mode) begin
         seg_reg <= CBTE_SEG_SYNC;
         seg_cnt_reg <= '0;
      end else if (tq_tick) begin
         if (seg_cnt_reg == seg_len - 1'b1) begin
            seg_cnt_reg <= '0;
            unique case (seg_reg) // [RQ16]
               CBTE_SEG_SYNC: seg_reg <= CBTE_SEG_PROP;
               CBTE_SEG_PROP: seg_reg <= CBTE_SEG_PH1;
               CBTE_SEG_PH1: seg_reg <= CBTE_SEG_PH2;
               CBTE_SEG_PH2: seg_reg <= CBTE_SEG_SYNC;
            endcase
         end else begin
            seg_cnt_reg <= seg_cnt_reg + 1'b1;
         end
      end
   end

   assign last_ph1_tq = (seg_reg == CBTE_SEG_PH1) && (seg_cnt_reg == phase1_tq - 1'b1);

   // samples at -TQ, -TQ/2 and the sample point at the close of phase 1
   always_ff @(posedge clk) begin
      if (srst) begin
         samples_reg <= 3'h7;
      end else if (last_ph1_tq && half_tick) begin // [RQ8]
         samples_reg <= {samples_reg[1:0], rx_sync_reg};
      end else if (tq_tick && ((seg_reg == CBTE_SEG_PH1 && seg_cnt_reg == phase1_tq - 5'h02) ||
                   (seg_reg == CBTE_SEG_PROP && seg_cnt_reg == seg_len - 1'b1 &&
                    phase1_tq == CBTE_SYNC_TQ))) begin // [RQ8]
         // a one-quantum phase 1 takes its early sample at the close of propagation
         samples_reg <= {samples_reg[1:0], rx_sync_reg};
      end
   end

   // bit stream outputs
   always_ff @(posedge clk) begin
      if (srst) begin
         bit_out <= '{bit_start: 1'b0, sample_point: 1'b0, rx_bit: 1'b1};
      end else begin
         bit_out.bit_start <= tq_tick && (seg_reg == CBTE_SEG_PH2) &&
                              (seg_cnt_reg == seg_len - 1'b1);
         bit_out.sample_point <= last_ph1_tq && tq_tick; // [RQ7]
         if (last_ph1_tq && tq_tick) begin
            if (cfg.triple_sample_en) begin
               bit_out.rx_bit <= (samples_reg[1] & samples_reg[0]) |
                                 (samples_reg[1] & rx_sync_reg) |
                                 (samples_reg[0] & rx_sync_reg); // [RQ9]
            end else begin
               bit_out.rx_bit <= rx_sync_reg; // [RQ10]
            end
         end
      end
   end

   // derived quantities for the rest of the controller; no reset of their own so they
   // already match the reset register values when reset is released
   always_ff @(posedge clk) begin
      resync_jump_tq <= {1'b0, cfg.resync_jump_sel} + 1'b1; // [RQ5]
      bit_len_tq <= CBTE_SYNC_TQ + CBTE_CNT_W'(cfg.propagation_len) + 1'b1 +
                    phase1_tq + phase2_len; // [RQ16]
   end
endmodule

// [verification/cbte_monitor.sv]
// Purpose: port-level checks of the bit timing engine
// Assumes: single clock domain, srst synchronous active high
// Notes: bound from tb_top
`timescale 1ns/1ps
module cbte_monitor
   import cbte_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // watched ports
   input wire logic config_mode,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire cbte_bit_type bit_out,
   input wire logic [2:0] resync_jump_tq,
   input wire logic [4:0] bit_len_tq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_cfg_held; config_mode [*3]; endsequence
   sequence s_run_held; !config_mode [*3]; endsequence
   property p_rdata_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
   property p_jump_range; resync_jump_tq inside {[3'h1:3'h4]}; endproperty
   property p_len_range; bit_len_tq inside {[5'h04:5'h19]}; endproperty
   // counting stands still while software reprograms the timing
   property p_halt; s_cfg_held |-> !bit_out.bit_start && !bit_out.sample_point; endproperty
   property p_cfg_stable;
      s_run_held |-> $stable(bit_len_tq) && $stable(resync_jump_tq);
   endproperty
   property p_sp_gap; bit_out.sample_point |=> !bit_out.sample_point && !bit_out.bit_start;
   endproperty
   property p_bs_gap; bit_out.bit_start |=> !bit_out.bit_start && !bit_out.sample_point;
   endproperty
   property p_rx_hold;
      !bit_out.sample_point && !$past(bit_out.sample_point) |-> $stable(bit_out.rx_bit);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data outside read slot");
   a_jump_range: assert property (p_jump_range)
      else $error("jump width out of range");
   a_len_range: assert property (p_len_range)
      else $error("bit length out of range");
   a_halt: assert property (p_halt)
      else $error("pulse while configuring");
   a_cfg_stable: assert property (p_cfg_stable)
      else $error("timing changed outside configuration");
   a_sp_gap: assert property (p_sp_gap)
      else $error("pulse right after sample point");
   a_bs_gap: assert property (p_bs_gap)
      else $error("pulse right after bit start");
   a_rx_hold: assert property (p_rx_hold)
      else $error("received bit moved between samples");
endmodule

// [verification/cbte_can_node.sv]
// Purpose: far node driving the receive pin one bit per slot
// Assumes: hard-synchronised to the bit starts it is shown
// Notes: idles recessive 1, as the pulled-up bus reads
`timescale 1ns/1ps
module cbte_can_node (
   // clock and bit boundary
   input wire logic clk,
   input wire logic bit_start,
   // bus level
   output logic pin
);
   logic [7:0] frame_bits;
   int left;
   initial begin
      pin = 1'b1;
      left = 0;
   end
   always @(posedge clk) begin
      if (bit_start) begin
         pin <= (left > 0) ? frame_bits[left-1] : 1'b1;
         left <= (left > 0) ? left - 1 : 0;
      end
   end
   task send(input logic [7:0] b);
      frame_bits = b;
      left = 8;
   endtask
endmodule

// [verification/tb_top.sv]
// Purpose: register and bit timing tests of the engine
// Assumes: clk 40 MHz, reset 4 cycles
// Notes: timing figures measured in clocks between pulses
`timescale 1ns/1ps
module tb_top;
   import cbte_pkg::*;
   logic clk, srst, config_mode, reg_wr, reg_rd, bus_receive_pin;
   logic [1:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, rd, pat;
   cbte_bit_type bit_out;
   logic [2:0] resync_jump_tq;
   logic [4:0] bit_len_tq;
   int n_mismatch, checks_done, cnt, q, pl, p1, p2;
   logic [7:0] cfg [4][3] = '{'{8'h01, 8'h91, 8'hFB}, '{8'h40, 8'h00, 8'h07},
      '{8'h82, 8'h68, 8'h01}, '{8'hC0, 8'hFF, 8'h07}};
   cbte_bit_timing dut (.clk(clk), .srst(srst), .config_mode(config_mode),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .bus_receive_pin(bus_receive_pin), .bit_out(bit_out),
      .resync_jump_tq(resync_jump_tq), .bit_len_tq(bit_len_tq));
   cbte_can_node node (.clk(clk), .bit_start(bit_out.bit_start), .pin(bus_receive_pin));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task close_out;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task wr(input logic [1:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   task rdr(input logic [1:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      rd = reg_rdata;
      @(posedge clk);
   endtask
   // bounded wait for a pulse; cnt holds edges waited
   task wait_ev(input logic sp);
      cnt = 0;
      do begin
         @(posedge clk);
         #1;
         cnt++;
      end while ((sp ? bit_out.sample_point : bit_out.bit_start) !== 1'b1 && cnt < 2000);
      if (cnt >= 2000) begin
         n_mismatch++;
         close_out;
      end
   endtask
   initial begin
      srst = 1'b1;
      config_mode = 1'b0;
      reg_addr = 2'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      for (int j = 0; j < 3; j++) begin
         rdr(2'(j));
         chk("reset value", 8'h00, rd);
      end
      for (int i = 0; i < 4; i++) begin
         config_mode <= 1'b1;
         @(posedge clk);
         for (int j = 0; j < 3; j++) wr(2'(j), cfg[i][j]);
         for (int j = 0; j < 3; j++) begin
            rdr(2'(j));
            chk("readback", (j == 2) ? (cfg[i][j] & 8'h07) : cfg[i][j], rd);
         end
         rdr(CBTE_ADDR_STATUS);
         chk("status segment", 8'h00, rd & 8'hF8);
         config_mode <= 1'b0;
         q = 2 * (cfg[i][0][5:0] + 1);
         pl = cfg[i][1][2:0] + 1;
         p1 = cfg[i][1][5:3] + 1;
         p2 = cfg[i][1][7] ? cfg[i][2][2:0] + 1 : ((p1 > 2) ? p1 : 2);
         wait_ev(1'b0);
         chk("jump", 8'(cfg[i][0][7:6] + 1), {5'h00, resync_jump_tq});
         chk("length", 8'(1 + pl + p1 + p2), {3'h0, bit_len_tq});
         wait_ev(1'b1);
         chk("sample offset", 8'(q * (1 + pl + p1)), 8'(cnt));
         pat = 8'h5A + 8'(i);
         node.send(pat);
         wait_ev(1'b0);
         chk("phase2 span", 8'(q * p2), 8'(cnt));
         for (int k = 7; k >= 0; k--) begin
            wait_ev(1'b1);
            @(posedge clk);
            #1;
            chk("rx bit", {7'h00, pat[k]}, {7'h00, bit_out.rx_bit});
         end
         $display("config %0d done", i);
      end
      wr(2'h0, 8'h3F);
      rdr(2'h0);
      chk("locked write", cfg[3][0], rd);
      close_out;
   end
endmodule
bind cbte_bit_timing cbte_monitor mon (.clk(clk), .srst(srst), .config_mode(config_mode),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bit_out(bit_out),
   .resync_jump_tq(resync_jump_tq), .bit_len_tq(bit_len_tq));
